//--- rtl/sbdl_link.sv
// Notes on behaviour
// - The pin is pseudo-open-drain and each side drives it only inside its own bit interval.
// - Bytes move most significant bit first at sixteen debug clock cycles per bit.
// - Five hundred twelve debug clock cycles with no host falling edge while a byte is open raise a link timeout.
// - A timeout drops the transfer in progress and touches no memory or mode state.
// - A clock-select input chooses the bus clock or the alternate debug clock as time base.
// - All link timing runs on the debug clock and host edges are brought into it.
// - Each bit is one of receive high, receive low, transmit high or transmit low.
// - With the pin pulled high at reset release the device selects normal mode.
// - A host holding the pin low at reset release requests active background mode.
// - The link accepts traffic without needing a reset first, except host bits that arrive while the two-entry receive buffer is full.
`timescale 1ns/10ps
`include "sbdl_defs.svh"

module sbdl_link
  import sbdl_pkg::*;
(
  // Clocks and reset.
  input wire logic core_clk_i,
  input wire logic alt_clk_en_i,
  input wire logic reset_n_i,
  // Configuration.
  input wire logic debug_clock_select_i,
  // Debug pin.
  input wire logic debug_pin_i,
  output logic debug_pin_o,
  output logic debug_pin_oe_o,
  // Received bytes toward the debug controller.
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  // Bytes to send to the host.
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // Status.
  output logic timeout_o,
  output logic busy_o,
  output logic debug_pin_mode_o,
  output logic mode_valid_o
);

  // ==========================================================================
  // Debug clock tick and pin synchronizer.
  logic tick;
  logic sync1_reg, sync2_reg, prev_reg;
  logic sync1_next, sync2_next, prev_next;
  logic fall;

  assign tick = debug_clock_select_i ? alt_clk_en_i : 1'b1;

  always_comb begin
    sync1_next = debug_pin_i;
    sync2_next = sync1_reg;
    prev_next = tick ? sync2_reg : prev_reg;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  assign fall = tick && prev_reg && !sync2_reg;

  // ==========================================================================
  // Mode strap caught after reset release.
  // The synchronizer leaves reset high, so the strap is taken only once the
  // pin level has passed both stages; earlier it would always read high.
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic debug_pin_reg, debug_pin_next;

  always_comb begin
    strap_cnt_next = (strap_cnt_reg == 2'h3) ? strap_cnt_reg : strap_cnt_reg + 2'h1;
    debug_pin_next = (strap_cnt_reg == 2'h2) ? !sync2_reg : debug_pin_reg;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_cnt_reg <= 2'h0;
      debug_pin_reg <= 1'b0;
    end else begin
      strap_cnt_reg <= strap_cnt_next;
      debug_pin_reg <= debug_pin_next;
    end
  end

  assign debug_pin_mode_o = debug_pin_reg;
  assign mode_valid_o = (strap_cnt_reg == 2'h3);

  // ==========================================================================
  // Two-entry receive buffer.
  sbdl_byte_t rxb_mem_reg [2];
  sbdl_byte_t rxb_mem_next [2];
  logic rxb_wr_reg, rxb_rd_reg;
  logic rxb_wr_next, rxb_rd_next;
  logic [1:0] rxb_cnt_reg, rxb_cnt_next;
  logic rxb_push, rxb_pop, rxb_ready;
  logic [7:0] rxb_din;

  assign rxb_ready = (rxb_cnt_reg != 2'h2);
  assign rx_valid_o = (rxb_cnt_reg != 2'h0);
  assign rx_data_o = rxb_mem_reg[rxb_rd_reg].data;
  assign rxb_pop = rx_valid_o && rx_ready_i;

  always_comb begin
    rxb_mem_next = rxb_mem_reg;
    rxb_wr_next = rxb_wr_reg;
    rxb_rd_next = rxb_rd_reg;
    if (rxb_push) begin
      rxb_mem_next[rxb_wr_reg].data = rxb_din;
      rxb_wr_next = !rxb_wr_reg;
    end
    if (rxb_pop) begin
      rxb_rd_next = !rxb_rd_reg;
    end
    rxb_cnt_next = rxb_cnt_reg + {1'b0, rxb_push} - {1'b0, rxb_pop};
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rxb_wr_reg <= 1'b0;
      rxb_rd_reg <= 1'b0;
      rxb_cnt_reg <= 2'h0;
    end else begin
      rxb_wr_reg <= rxb_wr_next;
      rxb_rd_reg <= rxb_rd_next;
      rxb_cnt_reg <= rxb_cnt_next;
    end
  end

  for (genvar gi = 0; gi < 2; gi++) begin : g_rxb_entry
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        rxb_mem_reg[gi] <= '0;
      end else begin
        rxb_mem_reg[gi] <= rxb_mem_next[gi];
      end
    end
  end

  // ==========================================================================
  // Link idle timer.
  // The timer saturates, so a long quiet link never wraps into a false
  // timeout; it only matters while a byte is open.
  logic [`SBDL_CNT_W-1:0] idle_reg, idle_next;
  logic idle_full;

  // True on the tick count at which a bit event falls due.
  function automatic logic cnt_at(input logic [`SBDL_CNT_W-1:0] c, input int unsigned n);
    return (c == n[`SBDL_CNT_W-1:0]);
  endfunction

  assign idle_full = cnt_at(idle_reg, `SBDL_TIMEOUT_CYCLES - 1);

  always_comb begin
    idle_next = idle_reg;
    if (tick) begin
      if (fall) begin
        idle_next = '0;
      end else if (!idle_full) begin
        idle_next = idle_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_reg <= '0;
    end else begin
      idle_reg <= idle_next;
    end
  end

  // ==========================================================================
  // Timeout flag: a one-cycle pulse when the idle timer runs out on an open byte.
  logic timeout_reg, timeout_next;
  logic abort;

  assign abort = tick && !fall && idle_full && busy_o;

  always_comb begin
    timeout_next = abort;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= timeout_next;
    end
  end

  assign timeout_o = timeout_reg;

  // ==========================================================================
  // Bit engine.
  sbdl_state_t state_reg, state_next;
  logic [`SBDL_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic tx_mode_reg, tx_mode_next;
  logic tx_bit;
  sbdl_pin_drv_t drv;

  assign tx_bit = shift_reg[7];
  assign tx_ready_o = !tx_mode_reg && (state_reg == SBDL_IDLE) && (bit_reg == 3'h0);
  assign busy_o = (state_reg != SBDL_IDLE) || (bit_reg != 3'h0);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    tx_mode_next = tx_mode_reg;
    rxb_push = 1'b0;
    rxb_din = {shift_reg[6:0], sync2_reg};
    if (tx_valid_i && tx_ready_o) begin
      tx_mode_next = 1'b1;
      shift_next = tx_data_i;
    end
    unique case (state_reg)
      SBDL_IDLE: begin
        if (fall && (tx_mode_reg || rxb_ready)) begin
          state_next = tx_mode_reg ? SBDL_TX_BIT : SBDL_RX_BIT;
          cnt_next = '0;
        end
      end
      SBDL_RX_BIT: begin
        if (tick) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_at(cnt_reg, `SBDL_SAMPLE_CYCLE)) begin
            shift_next = rxb_din;
            bit_next = bit_reg + 1'b1;
            rxb_push = (bit_reg == 3'h7);
            state_next = SBDL_IDLE;
          end
        end
      end
      SBDL_TX_BIT: begin
        if (tick) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_at(cnt_reg, `SBDL_BIT_CYCLES - 1)) begin
            shift_next = {shift_reg[6:0], 1'b0};
            bit_next = bit_reg + 1'b1;
            tx_mode_next = (bit_reg != 3'h7);
            state_next = SBDL_IDLE;
          end
        end
      end
    endcase
    if (abort) begin
      state_next = SBDL_IDLE;
      bit_next = 3'h0;
      tx_mode_next = 1'b0;
      rxb_push = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= SBDL_IDLE;
      cnt_reg <= '0;
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      tx_mode_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      tx_mode_reg <= tx_mode_next;
    end
  end

  // ==========================================================================
  // Pin drive: low for a zero, brief high speed-up for a one, else released.
  always_comb begin
    drv.o = 1'b0;
    drv.oe = 1'b0;
    if (state_reg == SBDL_TX_BIT) begin
      if (!tx_bit && cnt_reg < `SBDL_TX_LOW_END) begin
        drv.oe = 1'b1;
      end else if (tx_bit && cnt_reg >= `SBDL_TX_LOW_END && cnt_reg < `SBDL_SPEEDUP_END) begin
        drv.o = 1'b1;
        drv.oe = 1'b1;
      end
    end
  end

  assign debug_pin_o = drv.o;
  assign debug_pin_oe_o = drv.oe;

endmodule

//--- inc/sbdl_defs.svh
`ifndef SBDL_DEFS_SVH
`define SBDL_DEFS_SVH

// Serial bit timing in debug communication clock cycles.
`define SBDL_BIT_CYCLES 16
`define SBDL_CNT_W 10
// Idle cycles between host falling edges that end a transfer.
`define SBDL_TIMEOUT_CYCLES 512
// Cycle after the falling edge at which a received level is sampled.
`define SBDL_SAMPLE_CYCLE 10
// Cycle after the falling edge at which a driven low bit is released.
`define SBDL_TX_LOW_END 13
// Cycle after the falling edge at which the one-cycle active-high speed-up pulse for a one bit ends.
`define SBDL_SPEEDUP_END 14
`define SBDL_BYTE_W 8
`define SBDL_BIT_IDX_W 3

`endif

//--- inc/sbdl_pkg.sv
package sbdl_pkg;
  typedef enum logic [1:0] {
    SBDL_IDLE,
    SBDL_RX_BIT,
    SBDL_TX_BIT
  } sbdl_state_t;

  typedef struct packed {
    logic [7:0] data;
  } sbdl_byte_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sbdl_pin_drv_t;
endpackage

//--- tb/sbdl_link_checker.sv
`timescale 1ns/10ps
module sbdl_link_checker
  import sbdl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic debug_clock_select_i,
  input wire logic debug_pin_o,
  input wire logic debug_pin_oe_o,
  input wire logic rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic timeout_o,
  input wire logic busy_o,
  input wire logic debug_pin_mode_o,
  input wire logic mode_valid_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic drv0 = debug_pin_oe_o && !debug_pin_o;
  property p_low_len; $rose(drv0) && !debug_clock_select_i |-> drv0[*8]; endproperty
  a_low_len: assert property (p_low_len) else $error("driven low bit too short");
  property p_one_pulse; debug_pin_oe_o && debug_pin_o && !debug_clock_select_i |=> !drv0
    && !(debug_pin_oe_o && debug_pin_o); endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("speed-up pulse too long");
  property p_idle_free; !busy_o |-> !debug_pin_oe_o; endproperty
  a_idle_free: assert property (p_idle_free) else $error("pin driven while idle");
  property p_to_busy; timeout_o |-> $past(busy_o); endproperty
  a_to_busy: assert property (p_to_busy) else $error("timeout while idle");
  property p_to_pulse; timeout_o |=> !timeout_o; endproperty
  a_to_pulse: assert property (p_to_pulse) else $error("timeout not a pulse");
  property p_to_end; timeout_o |-> ##[0:1] !busy_o; endproperty
  a_to_end: assert property (p_to_end) else $error("transfer kept after timeout");
  property p_mode_hold; mode_valid_o |=> mode_valid_o && $stable(debug_pin_mode_o); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode strap changed");
  property p_rx_hold; rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("received byte lost");
  property p_tx_take; tx_valid_i && tx_ready_o |=> !tx_ready_o; endproperty
  a_tx_take: assert property (p_tx_take) else $error("second byte taken");
  c_timeout: cover property (timeout_o);
  c_pop: cover property (rx_valid_o && rx_ready_i);
  c_drive: cover property (drv0);
endmodule

bind sbdl_link sbdl_link_checker chk_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .debug_clock_select_i(debug_clock_select_i), .debug_pin_o(debug_pin_o),
  .debug_pin_oe_o(debug_pin_oe_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
  .rx_ready_i(rx_ready_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
  .timeout_o(timeout_o), .busy_o(busy_o), .debug_pin_mode_o(debug_pin_mode_o),
  .mode_valid_o(mode_valid_o));

//--- tb/sbdl_host_model.sv
`timescale 1ns/10ps
module sbdl_host_model (
  input wire logic core_clk_i,
  input wire logic pin_i,
  output logic pull_low_o
);
  initial pull_low_o = 1'b0;
  task automatic hold(input logic v);
    pull_low_o = v;
  endtask
  // One bit of 20 ticks scaled by k, 26 for a written zero; the host lets go before the device drives.
  task automatic bit_io(input logic rd, input logic v, input int k, output logic seen);
    int l;
    l = rd ? 2 : (v ? 3 : 16);
    @(negedge core_clk_i) pull_low_o = 1'b1;
    repeat (l * k - 1) @(negedge core_clk_i);
    pull_low_o = 1'b0;
    repeat ((10 - l) * k) @(negedge core_clk_i);
    seen = pin_i;
    repeat (10 * k) @(negedge core_clk_i);
  endtask
  task automatic put_byte(input logic [7:0] b, input int k);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b0, b[i], k, s);
  endtask
  task automatic get_byte(input int k, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, 1'b1, k, b[i]);
  endtask
endmodule

//--- tb/test_single_pin_background_debug_link.sv
`timescale 1ns/10ps
module test_single_pin_background_debug_link;
  import sbdl_pkg::*;
  logic core_clk_i, reset_n_i, sel, pull_low, rx_ready, tx_valid;
  logic alt_clk_en_i = 1'b0;
  logic pin_o, pin_oe, rx_valid, tx_ready, timeout, busy, debug_pin, mode_valid;
  logic [7:0] tx_data, rx_data, b;
  wire logic pin = !pull_low && !(pin_oe && !pin_o);
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  sbdl_link dut (.core_clk_i(core_clk_i), .alt_clk_en_i(alt_clk_en_i), .reset_n_i(reset_n_i),
    .debug_clock_select_i(sel), .debug_pin_i(pin), .debug_pin_o(pin_o), .debug_pin_oe_o(pin_oe),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready), .timeout_o(timeout), .busy_o(busy),
    .debug_pin_mode_o(debug_pin), .mode_valid_o(mode_valid));
  sbdl_host_model host (.core_clk_i(core_clk_i), .pin_i(pin), .pull_low_o(pull_low));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) alt_clk_en_i <= ~alt_clk_en_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic low);
    reset_n_i = 1'b0;
    host.hold(low);
    repeat (2) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    host.hold(1'b0);
    chk(8'(mode_valid), 8'h01);
    chk(8'(debug_pin), 8'(low));
  endtask
  task automatic rx_one(input logic [7:0] v, input int k);
    host.put_byte(v, k);
    chk(rx_data, v);
    chk(8'(rx_valid), 8'h01);
    rx_ready = 1'b1;
    @(negedge core_clk_i) rx_ready = 1'b0;
  endtask
  task automatic t_rx_fill();
    host.put_byte(8'hA5, 1);
    host.put_byte(8'h5A, 1);
    chk(rx_data, 8'hA5);
    rx_ready = 1'b1;
    @(negedge core_clk_i) chk(rx_data, 8'h5A);
    @(negedge core_clk_i) rx_ready = 1'b0;
    chk(8'(rx_valid), 8'h00);
  endtask
  task automatic t_tx();
    chk(8'(tx_ready), 8'h01);
    tx_data = 8'h3C;
    tx_valid = 1'b1;
    @(negedge core_clk_i) tx_valid = 1'b0;
    chk(8'(tx_ready), 8'h00);
    host.get_byte(1, b);
    chk(b, 8'h3C);
  endtask
  task automatic t_timeout();
    int n;
    logic s;
    n = 0;
    for (int i = 0; i < 3; i++) host.bit_io(1'b0, i[0], 1, s);
    while (timeout !== 1'b1 && n < 600) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(8'(n >= 486 && n <= 496), 8'h01);
    @(negedge core_clk_i) chk(8'(busy), 8'h00);
    rx_one(8'hC3, 1);
  endtask
  initial begin
    sel = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    do_reset(1'b1);
    do_reset(1'b0);
    t_rx_fill();
    t_tx();
    t_timeout();
    sel = 1'b1;
    rx_one(8'h96, 2);
    close_out();
  end
endmodule
